// File: pfc_consts.svh
// Purpose: Shared constants for the corrector pulse generator
// Assumes: 25 MHz system clock
// Notes: Offsets are byte addresses on the plain register port
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH

`define PFC_CLK_HZ 25000000
`define PFC_CLK_NS 40
`define PFC_PWM_HZ 80000
`define PFC_PERIOD_CYC (`PFC_CLK_HZ / `PFC_PWM_HZ)
`define PFC_TRIG_MIN_NS 1000
`define PFC_TRIG_MIN_CYC \
  ((`PFC_TRIG_MIN_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_ADC_HZ 12000000
// Converter cycles counted in halves: 7.5 and 12.5
`define PFC_ADC_SMP_HALF 15
`define PFC_ADC_CONV_HALF 25
`define PFC_ADC_CONV_CYC \
  (((`PFC_ADC_SMP_HALF + `PFC_ADC_CONV_HALF) * `PFC_CLK_HZ \
  + 2 * `PFC_ADC_HZ - 1) / (2 * `PFC_ADC_HZ))

`define PFC_GAIN_SHIFT 10
`define PFC_KPV_INIT 16'h06a4
`define PFC_KIV_INIT 16'h00d5
`define PFC_KPI_INIT 16'h00e6
`define PFC_KII_INIT 16'h0038
`define PFC_VLOOP_DIV 400
`define PFC_INTEG_LIM 32'h00ffffff

`define PFC_VREF_INIT 12'hb80
`define PFC_VDC_MAX 12'hd00
`define PFC_VDC_MIN 12'h600
`define PFC_IAC_MAX 12'hf00

`define PFC_REG_CTRL 8'h00
`define PFC_REG_STATUS 8'h04
`define PFC_REG_IRQ_STAT 8'h08
`define PFC_REG_IRQ_MASK 8'h0c
`define PFC_REG_VREF 8'h10
`define PFC_REG_DUTY 8'h14
`define PFC_REG_GAIN 8'h18
`define PFC_REG_SAMPLE 8'h1c

`define PFC_IRQ_CONV 0
`define PFC_IRQ_FAULT 1
`define PFC_IRQ_STATE 2
`define PFC_IRQ_W 3

`endif

// File: pfc_pkg.sv
// Purpose: Types for the corrector pulse generator
// Assumes: Nothing beyond the constants header
// Notes: Used by scoped name only
`default_nettype none
package pfc_pkg;
  typedef enum logic [1:0] {
    PFC_STOPPED,
    PFC_WAITING,
    PFC_STARTING,
    PFC_RUNNING
  } pfc_state_t;

  typedef enum logic [1:0] {
    PFC_SEL_KPV,
    PFC_SEL_KIV,
    PFC_SEL_KPI,
    PFC_SEL_KII
  } pfc_gain_sel_t;
endpackage
`default_nettype wire

// File: pfc_compare.sv
// Purpose: One compare channel of the shared period counter
// Assumes: Counter restarts at zero each period
// Notes: Pulse is high from period start until the width is reached
`default_nettype none
module pfc_compare #(
  parameter int W = 9
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] count,
  input wire logic [W-1:0] width,
  output logic pulse
);
  logic pulse_reg;
  logic pulse_next;

  always_comb
  begin
    pulse_next = (count < width);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pulse_reg <= 1'b0;
    else
      pulse_reg <= pulse_next;
  end

  assign pulse = pulse_reg;
endmodule // pfc_compare
`default_nettype wire

// File: pfc_pwm_adc_trigger.sv
// Purpose: Corrector pulse generator, conversion timing and control
// Assumes: All inputs synchronous to clk_sys; samples held by converter
// Notes: Period is rounded down to whole clock cycles
`include "pfc_consts.svh"
`default_nettype none
module pfc_pwm_adc_trigger (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic mains_present,
  input wire logic oc_fault_in,
  input wire logic [11:0] adc_vdc,
  input wire logic [11:0] adc_iac,
  input wire logic [11:0] adc_vac,
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic btn_right,
  input wire logic btn_left,
  input wire logic restore_button,
  output logic switch_drive_channel,
  output logic adc_trigger_channel,
  output logic adc_start,
  output logic led_red,
  output logic led_orange,
  output logic led_blue,
  output logic led_green,
  output logic irq
);
  localparam logic [8:0] PERIOD_LAST = 9'(`PFC_PERIOD_CYC - 1);
  localparam logic [8:0] TRIG_MIN = 9'(`PFC_TRIG_MIN_CYC);
  localparam logic [5:0] CONV_LAST = 6'(`PFC_ADC_CONV_CYC - 1);
  localparam logic [8:0] VDIV_LAST = 9'(`PFC_VLOOP_DIV - 1);

  pfc_pkg::pfc_state_t state_reg, state_next;
  pfc_pkg::pfc_gain_sel_t sel_reg, sel_next;
  logic [8:0] cnt_reg, cnt_next;
  logic [8:0] duty_reg, duty_next;
  logic [8:0] drv_w_reg, drv_w_next;
  logic [8:0] trg_w_reg, trg_w_next;
  logic trg_prev_reg;
  logic conv_busy_reg, conv_busy_next;
  logic [5:0] conv_cnt_reg, conv_cnt_next;
  logic pair_reg, pair_next;
  logic run_reg, run_next;
  logic [8:0] vdiv_reg, vdiv_next;
  logic [11:0] vdc_reg, iac_reg, vac_reg;
  logic [11:0] vdc_next, iac_next, vac_next;
  logic [11:0] vref_reg, vref_next, iref_reg, iref_next;
  logic signed [31:0] integ_v_reg, integ_v_next;
  logic signed [31:0] integ_i_reg, integ_i_next;
  logic [15:0] gain_reg [4];
  logic [15:0] gain_next [4];
  logic [4:0] btn_prev_reg;
  logic [`PFC_IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [`PFC_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic drive_pulse, trig_pulse, boundary, conv_done, fault;
  logic active;
  logic [4:0] btn_rise;
  logic signed [12:0] err_v, err_i;
  logic signed [31:0] sum_v, sum_i, acc_v, acc_i;

  always_comb
  begin
    boundary = (cnt_reg == PERIOD_LAST);
    active = (state_reg != pfc_pkg::PFC_WAITING);
    cnt_next = cnt_reg;
    if (!active)
      cnt_next = 9'h000;
    else if (boundary)
      cnt_next = 9'h000;
    else
      cnt_next = cnt_reg + 9'h001;
    drv_w_next = drv_w_reg;
    trg_w_next = trg_w_reg;
    if (boundary)
    begin
      drv_w_next = duty_reg;
      trg_w_next = ((duty_reg >> 1) < TRIG_MIN) ? TRIG_MIN
                   : (duty_reg >> 1);
    end
  end

  pfc_compare #(.W(9)) u_drive (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .count(cnt_reg),
    .width(drv_w_reg),
    .pulse(drive_pulse)
  );

  pfc_compare #(.W(9)) u_trig (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .count(cnt_reg),
    .width(trg_w_reg),
    .pulse(trig_pulse)
  );

  assign switch_drive_channel = drive_pulse &&
    (state_reg == pfc_pkg::PFC_STARTING ||
     state_reg == pfc_pkg::PFC_RUNNING);
  assign adc_trigger_channel = trig_pulse;
  assign adc_start = trg_prev_reg && !trig_pulse;

  always_comb
  begin
    conv_busy_next = conv_busy_reg;
    conv_cnt_next = conv_cnt_reg;
    conv_done = 1'b0;
    vdc_next = vdc_reg;
    iac_next = iac_reg;
    vac_next = vac_reg;
    pair_next = pair_reg;
    run_next = 1'b0;
    if (adc_start)
    begin
      conv_busy_next = 1'b1;
      conv_cnt_next = CONV_LAST;
    end
    else if (conv_busy_reg)
    begin
      if (conv_cnt_reg == 6'h00)
      begin
        conv_busy_next = 1'b0;
        conv_done = 1'b1;
        vdc_next = adc_vdc;
        iac_next = adc_iac;
        vac_next = adc_vac;
        pair_next = !pair_reg;
        run_next = pair_reg;
      end
      else
        conv_cnt_next = conv_cnt_reg - 6'h01;
    end
  end

  // Regulators; integrators clamped to avoid windup
  always_comb
  begin
    err_v = $signed({1'b0, vref_reg}) - $signed({1'b0, vdc_reg});
    acc_v = integ_v_reg +
      32'($signed({1'b0, gain_reg[1]}) * err_v);
    if (acc_v > $signed(`PFC_INTEG_LIM))
      acc_v = $signed(`PFC_INTEG_LIM);
    else if (acc_v < -$signed(`PFC_INTEG_LIM))
      acc_v = -$signed(`PFC_INTEG_LIM);
    sum_v = (acc_v + 32'($signed({1'b0, gain_reg[0]}) * err_v))
            >>> `PFC_GAIN_SHIFT;
    err_i = $signed({1'b0, iref_reg}) - $signed({1'b0, iac_reg});
    acc_i = integ_i_reg +
      32'($signed({1'b0, gain_reg[3]}) * err_i);
    if (acc_i > $signed(`PFC_INTEG_LIM))
      acc_i = $signed(`PFC_INTEG_LIM);
    else if (acc_i < -$signed(`PFC_INTEG_LIM))
      acc_i = -$signed(`PFC_INTEG_LIM);
    sum_i = (acc_i + 32'($signed({1'b0, gain_reg[2]}) * err_i))
            >>> `PFC_GAIN_SHIFT;
    integ_v_next = integ_v_reg;
    integ_i_next = integ_i_reg;
    iref_next = iref_reg;
    duty_next = duty_reg;
    vdiv_next = vdiv_reg;
    if (state_reg == pfc_pkg::PFC_STOPPED ||
        state_reg == pfc_pkg::PFC_WAITING)
    begin
      integ_v_next = 32'sh0;
      integ_i_next = 32'sh0;
      duty_next = 9'h000;
      vdiv_next = 9'h000;
    end
    else if (run_reg)
    begin
      // voltage loop divider
      // First run sets a reference at once
      vdiv_next = (vdiv_reg == VDIV_LAST) ? 9'h000 : vdiv_reg + 9'h001;
      if (vdiv_reg == 9'h000)
      begin
        integ_v_next = acc_v;
        if (sum_v < 0)
          iref_next = 12'h000;
        else if (sum_v > 32'sd4095)
          iref_next = 12'hfff;
        else
          iref_next = sum_v[11:0];
      end
      integ_i_next = acc_i;
      if (sum_i < 0)
        duty_next = 9'h000;
      else if (sum_i > $signed({23'h0, PERIOD_LAST}))
        duty_next = PERIOD_LAST;
      else
        duty_next = sum_i[8:0];
    end
  end

  always_comb
  begin
    state_next = state_reg;
    fault = 1'b0;
    if (state_reg == pfc_pkg::PFC_STARTING ||
        state_reg == pfc_pkg::PFC_RUNNING)
      fault = oc_fault_in || (vdc_reg > `PFC_VDC_MAX) ||
              (state_reg == pfc_pkg::PFC_RUNNING &&
               vdc_reg < `PFC_VDC_MIN) ||
              (iac_reg > `PFC_IAC_MAX);
    unique case (state_reg)
      pfc_pkg::PFC_WAITING:
        if (mains_present)
          state_next = pfc_pkg::PFC_STARTING;
      pfc_pkg::PFC_STARTING:
        if (fault)
          state_next = pfc_pkg::PFC_STOPPED;
        else if (run_reg)
          state_next = pfc_pkg::PFC_RUNNING;
      pfc_pkg::PFC_RUNNING:
        if (fault)
          state_next = pfc_pkg::PFC_STOPPED;
      pfc_pkg::PFC_STOPPED:
        if (reg_wr && reg_addr == `PFC_REG_CTRL && reg_wdata[0])
          state_next = pfc_pkg::PFC_WAITING;
    endcase
  end

  assign led_red = (state_reg == pfc_pkg::PFC_STOPPED);
  assign led_orange = (state_reg == pfc_pkg::PFC_WAITING);
  assign led_blue = (state_reg == pfc_pkg::PFC_STARTING);
  assign led_green = (state_reg == pfc_pkg::PFC_RUNNING);

  always_comb
  begin
    btn_rise = {btn_up, btn_down, btn_right, btn_left, restore_button}
               & ~btn_prev_reg;
    sel_next = sel_reg;
    for (int k = 0; k < 4; k++)
      gain_next[k] = gain_reg[k];
    if (state_reg == pfc_pkg::PFC_RUNNING)
    begin
      if (btn_rise[4])
        sel_next = pfc_pkg::pfc_gain_sel_t'(sel_reg - 2'd1);
      else if (btn_rise[3])
        sel_next = pfc_pkg::pfc_gain_sel_t'(sel_reg + 2'd1);
      if (btn_rise[0])
      begin
        unique case (sel_reg)
          pfc_pkg::PFC_SEL_KPV: gain_next[0] = `PFC_KPV_INIT;
          pfc_pkg::PFC_SEL_KIV: gain_next[1] = `PFC_KIV_INIT;
          pfc_pkg::PFC_SEL_KPI: gain_next[2] = `PFC_KPI_INIT;
          pfc_pkg::PFC_SEL_KII: gain_next[3] = `PFC_KII_INIT;
        endcase
      end
      else if (btn_rise[2] && gain_reg[sel_reg] != 16'hffff)
        gain_next[sel_reg] = gain_reg[sel_reg] + 16'h0001;
      else if (btn_rise[1] && gain_reg[sel_reg] != 16'h0000)
        gain_next[sel_reg] = gain_reg[sel_reg] - 16'h0001;
    end
  end

  // Register port; a set event wins over a clear
  always_comb
  begin
    vref_next = vref_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (reg_wr && reg_addr == `PFC_REG_VREF)
      vref_next = reg_wdata[11:0];
    if (reg_wr && reg_addr == `PFC_REG_IRQ_MASK)
      irq_mask_next = reg_wdata[`PFC_IRQ_W-1:0];
    if (reg_wr && reg_addr == `PFC_REG_IRQ_STAT)
      irq_stat_next = irq_stat_reg & ~reg_wdata[`PFC_IRQ_W-1:0];
    if (conv_done && pair_reg)
      irq_stat_next[`PFC_IRQ_CONV] = 1'b1;
    if (fault)
      irq_stat_next[`PFC_IRQ_FAULT] = 1'b1;
    if (state_next != state_reg)
      irq_stat_next[`PFC_IRQ_STATE] = 1'b1;
    rdata_next = 32'h00000000;
    if (reg_rd)
    begin
      case (reg_addr)
        `PFC_REG_STATUS: rdata_next = {26'h0, sel_reg, conv_busy_reg,
                                       mains_present, state_reg};
        `PFC_REG_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
        `PFC_REG_IRQ_MASK: rdata_next = {29'h0, irq_mask_reg};
        `PFC_REG_VREF: rdata_next = {20'h0, vref_reg};
        `PFC_REG_DUTY: rdata_next = {7'h0, trg_w_reg, 7'h0, drv_w_reg};
        `PFC_REG_GAIN: rdata_next = {gain_reg[sel_reg], 4'h0, iref_reg};
        `PFC_REG_SAMPLE: rdata_next = {8'h0, vac_reg, iac_reg[11:4],
                                       vdc_reg[11:8]};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_reg <= pfc_pkg::PFC_WAITING;
      sel_reg <= pfc_pkg::PFC_SEL_KPV;
      cnt_reg <= 9'h000;
      duty_reg <= 9'h000;
      drv_w_reg <= 9'h000;
      trg_w_reg <= 9'h000;
      trg_prev_reg <= 1'b0;
      conv_busy_reg <= 1'b0;
      conv_cnt_reg <= 6'h00;
      pair_reg <= 1'b0;
      run_reg <= 1'b0;
      vdiv_reg <= 9'h000;
      vdc_reg <= 12'h000;
      iac_reg <= 12'h000;
      vac_reg <= 12'h000;
      vref_reg <= `PFC_VREF_INIT;
      iref_reg <= 12'h000;
      integ_v_reg <= 32'sh0;
      integ_i_reg <= 32'sh0;
      gain_reg[0] <= `PFC_KPV_INIT;
      gain_reg[1] <= `PFC_KIV_INIT;
      gain_reg[2] <= `PFC_KPI_INIT;
      gain_reg[3] <= `PFC_KII_INIT;
      btn_prev_reg <= 5'h00;
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      cnt_reg <= cnt_next;
      duty_reg <= duty_next;
      drv_w_reg <= drv_w_next;
      trg_w_reg <= trg_w_next;
      trg_prev_reg <= trig_pulse;
      conv_busy_reg <= conv_busy_next;
      conv_cnt_reg <= conv_cnt_next;
      pair_reg <= pair_next;
      run_reg <= run_next;
      vdiv_reg <= vdiv_next;
      vdc_reg <= vdc_next;
      iac_reg <= iac_next;
      vac_reg <= vac_next;
      vref_reg <= vref_next;
      iref_reg <= iref_next;
      integ_v_reg <= integ_v_next;
      integ_i_reg <= integ_i_next;
      for (int k = 0; k < 4; k++)
        gain_reg[k] <= gain_next[k];
      btn_prev_reg <= {btn_up, btn_down, btn_right, btn_left,
                       restore_button};
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule // pfc_pwm_adc_trigger
`default_nettype wire

// File: pfc_properties.sv
// Purpose: Port-level checks for the corrector pulse generator
// Assumes: Bound to every instance of the top module
// Notes: Helper counters measure trigger width and period length
`default_nettype none
module pfc_properties (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic mains_present,
  input wire logic oc_fault_in,
  input wire logic [11:0] adc_vdc,
  input wire logic [11:0] adc_iac,
  input wire logic [11:0] adc_vac,
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic btn_right,
  input wire logic btn_left,
  input wire logic restore_button,
  input wire logic switch_drive_channel,
  input wire logic adc_trigger_channel,
  input wire logic adc_start,
  input wire logic led_red,
  input wire logic led_orange,
  input wire logic led_blue,
  input wire logic led_green,
  input wire logic irq
);
  localparam int PERIOD = 312;
  localparam int TRIG_MIN = 25;
  logic [15:0] hi_cnt_reg;
  logic [15:0] hi_cnt_next;
  logic [15:0] per_cnt_reg;
  logic [15:0] per_cnt_next;
  logic trig_q_reg;
  logic trig_rise;

  assign trig_rise = adc_trigger_channel && !trig_q_reg;
  // Period count clears in waiting, where the counter is held
  always_comb
  begin
    hi_cnt_next = adc_trigger_channel ? hi_cnt_reg + 16'h0001 : 16'h0000;
    per_cnt_next = per_cnt_reg;
    if (led_orange)
      per_cnt_next = 16'h0000;
    else if (trig_rise)
      per_cnt_next = 16'h0001;
    else if (per_cnt_reg != 16'h0000 && per_cnt_reg != 16'hffff)
      per_cnt_next = per_cnt_reg + 16'h0001;
  end
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      hi_cnt_reg <= 16'h0000;
      per_cnt_reg <= 16'h0000;
      trig_q_reg <= 1'b0;
    end
    else
    begin
      hi_cnt_reg <= hi_cnt_next;
      per_cnt_reg <= per_cnt_next;
      trig_q_reg <= adc_trigger_channel;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_period_fixed_len: assert property (
    trig_rise && per_cnt_reg != 16'h0000 |-> per_cnt_reg == PERIOD)
    else $error("pwm period length off");
  a_trig_min_width: assert property (
    $fell(adc_trigger_channel) && !led_orange |-> hi_cnt_reg >= TRIG_MIN)
    else $error("trigger pulse too short");
  a_start_on_fall: assert property (
    $fell(adc_trigger_channel) && !led_orange |-> ##[0:1] adc_start)
    else $error("no conversion start after trigger end");
  a_start_single_pulse: assert property (
    adc_start |-> !adc_trigger_channel ##1 !adc_start)
    else $error("conversion start not a lone pulse");
  a_leds_one_hot: assert property (
    $onehot({led_red, led_orange, led_blue, led_green}))
    else $error("state lights not one hot");
  a_drive_off_idle: assert property (
    led_red || led_orange |-> !switch_drive_channel)
    else $error("switch driven while stopped");
  a_drive_with_trig: assert property (
    $rose(switch_drive_channel) && !$past(led_orange)
    |-> $rose(adc_trigger_channel))
    else $error("drive pulse not at period start");
  a_fault_stops_run: assert property (
    oc_fault_in && (led_blue || led_green) |-> ##[1:4] led_red)
    else $error("fault did not stop control");
  a_mains_starts_run: assert property (
    led_orange && mains_present |-> ##[1:4] led_blue)
    else $error("mains did not start control");
  a_rdata_idle_zero: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");

  c_running: cover property (led_green);
  c_fault: cover property (oc_fault_in && led_green);
  c_irq: cover property (irq);
  c_drive: cover property (switch_drive_channel);
endmodule // pfc_properties

bind pfc_pwm_adc_trigger pfc_properties pfc_properties_i (
  .clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .mains_present, .oc_fault_in, .adc_vdc, .adc_iac, .adc_vac, .btn_up,
  .btn_down, .btn_right, .btn_left, .restore_button, .switch_drive_channel,
  .adc_trigger_channel, .adc_start, .led_red, .led_orange, .led_blue,
  .led_green, .irq
);
`default_nettype wire

// File: pfc_power_model.sv
// Purpose: Power stage and converter seen from the pulse generator
// Assumes: Results latched at conversion start, held to the next one
// Notes: Levels are parameters; a real stage would ripple
`default_nettype none
module pfc_power_model #(
  parameter logic [11:0] VDC = 12'hb00,
  parameter logic [11:0] IAC = 12'h400,
  parameter logic [11:0] VAC = 12'h300
) (
  input wire logic clk_sys,
  input wire logic adc_start,
  output logic [11:0] adc_vdc,
  output logic [11:0] adc_iac,
  output logic [11:0] adc_vac
);
  // Before the first conversion the lines show no valid level
  initial
  begin
    adc_vdc = ~VDC;
    adc_iac = ~IAC;
    adc_vac = ~VAC;
  end
  always @(posedge clk_sys)
    if (adc_start)
    begin
      adc_vdc <= VDC;
      adc_iac <= IAC;
      adc_vac <= VAC;
    end
endmodule // pfc_power_model
`default_nettype wire

// File: tb_top.sv
// Purpose: Self-checking bench for the corrector pulse generator
// Assumes: Partner model stands in for the power stage
// Notes: Gains, duty and status are read over the register port
`include "pfc_consts.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, mains_present = 1'b0;
  logic oc_fault_in = 1'b0;
  logic [4:0] btn = 5'h00;
  logic [11:0] adc_vdc, adc_iac, adc_vac;
  logic switch_drive_channel, adc_trigger_channel, adc_start, irq;
  logic led_red, led_orange, led_blue, led_green;
  logic [31:0] reg_rdata, d;
  int num_errors = 0, check_count = 0, cycles = 0, n;

  pfc_pwm_adc_trigger pfc_pwm_adc_trigger_i (.clk_sys, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mains_present, .oc_fault_in,
    .adc_vdc, .adc_iac, .adc_vac, .btn_up(btn[0]), .btn_down(btn[1]),
    .btn_right(btn[2]), .btn_left(btn[3]), .restore_button(btn[4]),
    .switch_drive_channel, .adc_trigger_channel, .adc_start, .led_red,
    .led_orange, .led_blue, .led_green, .irq);
  // Low current so the current loop soon asks for a nonzero width
  pfc_power_model #(.VDC(12'hb00), .IAC(12'h040), .VAC(12'h300))
    pfc_power_model_i (.clk_sys, .adc_start, .adc_vdc, .adc_iac, .adc_vac);

  initial
    forever #20 clk_sys = ~clk_sys;

  task automatic test_done();
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Ceiling well above the few thousand cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic press(input int i);
    @(posedge clk_sys);
    btn[i] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    btn[i] <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic chk_gain(input logic [15:0] exp);
    rd(`PFC_REG_GAIN, d);
    chk({16'h0, d[31:16]}, {16'h0, exp});
  endtask

  task automatic t_reset();
    chk({led_red, led_orange, led_blue, led_green}, 4'b0100);
    chk(switch_drive_channel, 1'b0);
    rd(`PFC_REG_VREF, d);
    chk(d, 32'h0b80);
    rd(8'h3c, d);
    chk(d, 32'h0);
  endtask

  task automatic t_start();
    @(posedge clk_sys) mains_present <= 1'b1;
    for (n = 0; n < 3000 && !led_green; n++) @(negedge clk_sys);
    chk(led_green, 1'b1);
    rd(`PFC_REG_STATUS, d);
    chk(d[5:0], 6'h07);
    // First routine: (1700 + 213) * 0x80 >> 10
    rd(`PFC_REG_GAIN, d);
    chk(d[11:0], 12'h0ef);
  endtask

  task automatic t_adjust();
    press(2);
    chk_gain(16'h06a5);
    press(3);
    press(3);
    chk_gain(16'h06a3);
    press(4);
    chk_gain(16'h06a4);
  endtask

  task automatic t_gains();
    logic [15:0] def [4];
    def = '{16'h06a4, 16'h00d5, 16'h00e6, 16'h0038};
    for (int i = 0; i < 4; i++)
    begin
      rd(`PFC_REG_STATUS, d);
      chk(d[5:4], i[1:0]);
      chk_gain(def[i]);
      if (i < 3)
        press(1);
    end
    press(0);
    rd(`PFC_REG_STATUS, d);
    chk(d[5:4], 2'h2);
  endtask

  // Rise to rise of the trigger, sampled away from the clock edge
  task automatic t_period_duty();
    n = 0;
    while (adc_trigger_channel) @(negedge clk_sys);
    while (!adc_trigger_channel) @(negedge clk_sys);
    while (adc_trigger_channel) @(negedge clk_sys) n++;
    while (!adc_trigger_channel) @(negedge clk_sys) n++;
    chk(n, 312);
    rd(`PFC_REG_DUTY, d);
    n = d[8:1] < 25 ? 25 : d[8:1];
    chk(d[24:16], n);
  endtask

  task automatic t_conv();
    do @(negedge clk_sys); while (!adc_start);
    repeat (15) @(posedge clk_sys);
    rd(`PFC_REG_STATUS, d);
    chk(d[3], 1'b1);
    repeat (27) @(posedge clk_sys);
    rd(`PFC_REG_STATUS, d);
    chk(d[3], 1'b0);
    rd(`PFC_REG_SAMPLE, d);
    chk(d[23:12], 12'h300);
  endtask

  task automatic t_fault();
    wr(`PFC_REG_IRQ_MASK, 32'h0);
    wr(`PFC_REG_IRQ_STAT, 32'h7);
    n = 0;
    repeat (624) @(negedge clk_sys) n += switch_drive_channel;
    chk(n != 0, 1'b1);
    @(posedge clk_sys) oc_fault_in <= 1'b1;
    for (n = 0; n < 8 && !led_red; n++) @(negedge clk_sys);
    chk(led_red, 1'b1);
    n = 0;
    repeat (400) @(negedge clk_sys) n += switch_drive_channel;
    chk(n, 0);
    @(posedge clk_sys) oc_fault_in <= 1'b0;
    rd(`PFC_REG_IRQ_STAT, d);
    chk({d[1], irq}, 2'b10);
    wr(`PFC_REG_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1);
    wr(`PFC_REG_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    wr(`PFC_REG_CTRL, 32'h1);
    for (n = 0; n < 3000 && !led_green; n++) @(negedge clk_sys);
    chk(led_green, 1'b1);
  endtask

  initial
  begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_start();
    t_adjust();
    t_gains();
    t_period_duty();
    t_conv();
    t_fault();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
